//--- src/spc_defs.svh
// Offsets, field positions, reset values and timing of the serial port control bank
`ifndef SPC_DEFS_SVH
`define SPC_DEFS_SVH

// Register port geometry and offsets
`define SPC_ADDR_W      5
`define SPC_DATA_W      16
`define SPC_OFF_CTRL    5'h00
`define SPC_OFF_STAT    5'h01

// Control register fields
`define SPC_B_RESET     15
`define SPC_B_LOOP      14
`define SPC_B_SPD_LSB   13
`define SPC_B_ANEN      12
`define SPC_B_POWERDOWN_STRAP_INPUT     11
`define SPC_B_RSV10     10
`define SPC_B_RESTART   9
`define SPC_B_RSV8      8
`define SPC_B_SPD_MSB   6

// Status register fields
`define SPC_S_LINK      0
`define SPC_S_PRST      1
`define SPC_S_ANRS      2
`define SPC_S_ROLE      3

// Reset values and strap decode
`define SPC_SPD_RST     2'h2
`define SPC_RSV8_VAL    1'h1
`define SPC_PD_MODE     3'h5

// Timing, in nanoseconds, and the cycle conversion (least times round up)
`define SPC_CLK_NS      50
`define SPC_PRST_NS     800
`define SPC_ANRS_NS     200
`define SPC_CYC(ns)     (((ns) + `SPC_CLK_NS - 1) / `SPC_CLK_NS)

`endif

//--- src/spc_pkg.sv
// Types shared by the serial port control bank
package spc_pkg;

  // Sequencer states: idle, port reset, auto-negotiation restart
  typedef enum logic [1:0] {
    SPC_IDLE = 2'h0,
    SPC_PRST = 2'h1,
    SPC_ANRS = 2'h2
  } spc_state_t;

  // Speed pair, upper bit first: 2'h2 gigabit, 2'h1 hundred
  typedef logic [1:0] spc_speed_t;

endpackage

//--- src/spc_ctrl.sv
// Serial port control register bank with port reset, loopback and autoneg sequencing
//
// Functional notes
// - Writing port reset bit resets port state machines at once, bit self-clears when done.
// - Port reset affects only this serial port bank, nothing else.
// - With loopback set, internal transmit data returns on internal receive data.
// - Loopback forces link status down while it stays enabled.
// - Mode select zero: speed bits follow resolved speed, 10 gigabit, 01 hundred.
// - Mode select one: speed bits are writable and hold last written value.
// - Any change of autoneg enable breaks link and restarts autoneg.
// - Toggling autoneg enable either way also sets the restart bit.
// - Hardware reset loads autoneg enable from the autoneg strap.
// - Hardware reset sets power down only if power strap high and mode straps 101.
// - Writing restart bit restarts autoneg, then the bit clears itself.
// - Autoneg restarts after hardware reset, port reset and enable change.
// - Mode select zero picks system-side role, one picks media-side role.
`timescale 1ns/1ps
`default_nettype none
`include "spc_defs.svh"

module spc_ctrl #(
  parameter int DATA_W     = 8,
  parameter int CNT_W      = 8,
  parameter int PRST_CYC   = `SPC_CYC(`SPC_PRST_NS),
  parameter int ANRS_CYC   = `SPC_CYC(`SPC_ANRS_NS)
) (
  input  wire logic                   ref_clk_in,
  input  wire logic                   reset_in,
  // Register port
  input  wire logic [`SPC_ADDR_W-1:0] addr_in,
  input  wire logic [`SPC_DATA_W-1:0] wdata_in,
  input  wire logic                   wr_in,
  input  wire logic                   rd_in,
  output logic      [`SPC_DATA_W-1:0] rdata_out,
  // Straps
  input  wire logic                   autoneg_strap_input_in,
  input  wire logic                   powerdown_strap_input_in,
  input  wire logic [2:0]             config_strap_in,
  // Mode select and resolved speed from elsewhere in the port
  input  wire logic                   media_mode_in,
  input  wire spc_pkg::spc_speed_t    resolved_speed_in,
  input  wire logic                   line_link_in,
  // Internal data bus
  input  wire logic [DATA_W-1:0]      tx_data_in,
  input  wire logic [DATA_W-1:0]      line_rx_data_in,
  output logic      [DATA_W-1:0]      rx_data_out,
  // Controls toward the port logic
  output logic                        port_sm_reset_out,
  output logic                        aneg_restart_out,
  output logic                        aneg_enable_out,
  output logic                        power_down_out,
  output logic                        loopback_out,
  output spc_pkg::spc_speed_t         speed_out,
  output logic                        media_role_out,
  output logic                        link_up_out
);
  import spc_pkg::*;

  // Counts must fit the counter and be at least one cycle
  generate
    if (PRST_CYC < 1 || PRST_CYC >= (1 << CNT_W)) begin : g_bad_prst
      $error("PRST_CYC out of range for CNT_W");
    end
    if (ANRS_CYC < 1 || ANRS_CYC >= (1 << CNT_W)) begin : g_bad_anrs
      $error("ANRS_CYC out of range for CNT_W");
    end
    if (DATA_W < 1) begin : g_bad_data
      $error("DATA_W must be positive");
    end
    if (CNT_W < 2 || CNT_W > 16) begin : g_bad_cnt
      $error("CNT_W must be 2 to 16");
    end
  endgenerate

  localparam logic [CNT_W-1:0] PRST_LOAD = CNT_W'(PRST_CYC - 1);
  localparam logic [CNT_W-1:0] ANRS_LOAD = CNT_W'(ANRS_CYC - 1);
  localparam logic [CNT_W-1:0] CNT_ZERO  = '0;
  localparam logic [CNT_W-1:0] CNT_ONE   = CNT_W'(1);

  spc_state_t             state_reg;
  spc_state_t             state_next;
  logic [CNT_W-1:0]       cnt_reg;
  logic [CNT_W-1:0]       cnt_next;
  logic                   strap_pend_reg;
  logic                   loop_reg;
  logic                   loop_next;
  logic                   anen_reg;
  logic                   anen_next;
  logic                   powerdown_strap_input_reg;
  logic                   powerdown_strap_input_next;
  logic                   rsv10_reg;
  logic                   rsv10_next;
  spc_speed_t             spd_sw_reg;
  spc_speed_t             spd_sw_next;
  logic [`SPC_DATA_W-1:0] rdata_reg;
  logic [DATA_W-1:0]      rx_data_reg;
  spc_speed_t             speed_reg;
  logic                   role_reg;
  logic                   link_reg;

  // Address decode and write qualification
  wire ctrl_sel = (addr_in == `SPC_OFF_CTRL);
  wire stat_sel = (addr_in == `SPC_OFF_STAT);
  wire in_prst  = (state_reg == SPC_PRST);
  wire in_anrs  = (state_reg == SPC_ANRS);
  wire in_idle  = (state_reg == SPC_IDLE);
  // Writes during a port reset are dropped; the bank is being rebuilt
  wire ctrl_wr  = wr_in & ctrl_sel & ~in_prst;
  // Field writes; a port reset write leaves the retained fields alone
  wire keep_wr  = ctrl_wr & ~wdata_in[`SPC_B_RESET];

  // Requests decoded from a control write
  wire prst_req    = ctrl_wr & wdata_in[`SPC_B_RESET];
  wire anen_change = ctrl_wr & (wdata_in[`SPC_B_ANEN] != anen_reg);
  wire rst_wr      = ctrl_wr & wdata_in[`SPC_B_RESTART];
  // First edge after hardware reset, an enable toggle or a restart write
  wire an_req      = strap_pend_reg | anen_change | rst_wr;

  // Strap decode for power down
  wire pd_strap = powerdown_strap_input_in &
                  (config_strap_in == `SPC_PD_MODE);

  // Speed pair seen by software and the port
  wire spc_speed_t spd_live = media_mode_in ? spd_sw_reg
                                            : resolved_speed_in;

  // Control word as read back
  wire restart_bit = in_anrs;
  wire [`SPC_DATA_W-1:0] ctrl_word = {
    in_prst,
    loop_reg,
    spd_live[0],
    anen_reg,
    powerdown_strap_input_reg,
    rsv10_reg,
    restart_bit,
    `SPC_RSV8_VAL,
    1'h0,
    spd_live[1],
    6'h00
  };

  // Status word: link seen by the MAC side, sequencer activity, role
  wire [`SPC_DATA_W-1:0] stat_word = {
    12'h000,
    media_mode_in,
    in_anrs,
    in_prst,
    link_reg
  };

  // Read mux, unmapped addresses return zero
  wire [`SPC_DATA_W-1:0] rd_word = ctrl_sel ? ctrl_word :
                                   stat_sel ? stat_word : 16'h0000;
  // Strobe selects the word; between reads the port shows zero
  wire [`SPC_DATA_W-1:0] rd_next = rd_in ? rd_word : 16'h0000;

  // Receive source: transmit data replaces line data in loopback
  wire [DATA_W-1:0] rx_sel = loop_reg ? tx_data_in : line_rx_data_in;
  // Link held down in loopback, in any sequencer window and in power down
  wire link_ok = line_link_in & ~loop_reg & in_idle & ~powerdown_strap_input_reg;

  // Sequencer: port reset first, then autoneg restart window
  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    unique case (state_reg)
      SPC_IDLE: begin
        if (prst_req) begin
          state_next = SPC_PRST;
          cnt_next   = PRST_LOAD;
        end else if (an_req) begin
          state_next = SPC_ANRS;
          cnt_next   = ANRS_LOAD;
        end
      end
      SPC_PRST: begin
        if (cnt_reg == CNT_ZERO) begin
          // Reset done: bit clears and autoneg restarts on its own
          state_next = SPC_ANRS;
          cnt_next   = ANRS_LOAD;
        end else begin
          cnt_next = cnt_reg - CNT_ONE;
        end
      end
      SPC_ANRS: begin
        if (prst_req) begin
          state_next = SPC_PRST;
          cnt_next   = PRST_LOAD;
        end else if (an_req) begin
          // New request in the last cycle still wins over self-clear
          cnt_next = ANRS_LOAD;
        end else if (cnt_reg == CNT_ZERO) begin
          state_next = SPC_IDLE;
        end else begin
          cnt_next = cnt_reg - CNT_ONE;
        end
      end
      default: begin
        state_next = SPC_IDLE;
        cnt_next   = CNT_ZERO;
      end
    endcase
  end

  // Loopback: written freely, cleared by a port reset
  always_comb begin
    loop_next = loop_reg;
    if (prst_req) begin
      loop_next = 1'h0;
    end else if (ctrl_wr) begin
      loop_next = wdata_in[`SPC_B_LOOP];
    end
  end

  // Enable and power down load straps on first edge, reserved resets to zero and takes writes; all three retained by port reset
  always_comb begin
    anen_next  = anen_reg;
    powerdown_strap_input_next = powerdown_strap_input_reg;
    rsv10_next = rsv10_reg;
    if (strap_pend_reg) begin
      anen_next  = autoneg_strap_input_in;
      powerdown_strap_input_next = pd_strap;
    end else if (keep_wr) begin
      anen_next  = wdata_in[`SPC_B_ANEN];
      powerdown_strap_input_next = wdata_in[`SPC_B_POWERDOWN_STRAP_INPUT];
      rsv10_next = wdata_in[`SPC_B_RSV10];
    end
  end

  // Software speed pair only takes writes in media mode
  always_comb begin
    spd_sw_next = spd_sw_reg;
    if (keep_wr & media_mode_in) begin
      spd_sw_next = {wdata_in[`SPC_B_SPD_MSB],
                     wdata_in[`SPC_B_SPD_LSB]};
    end
  end

  // Sequencer and counter
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      state_reg <= SPC_IDLE;
      cnt_reg   <= CNT_ZERO;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
    end
  end

  // Strap capture is armed by reset and fires once after release
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      strap_pend_reg <= 1'h1;
    end else begin
      strap_pend_reg <= 1'h0;
    end
  end

  // Loopback; the only control field that a port reset clears
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      loop_reg <= 1'h0;
    end else begin
      loop_reg <= loop_next;
    end
  end

  // Retained fields; other banks never see the port reset
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      anen_reg  <= 1'h0;
      powerdown_strap_input_reg <= 1'h0;
      rsv10_reg <= 1'h0;
    end else begin
      anen_reg  <= anen_next;
      powerdown_strap_input_reg <= powerdown_strap_input_next;
      rsv10_reg <= rsv10_next;
    end
  end

  // Software speed pair, kept across a port reset
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      spd_sw_reg <= `SPC_SPD_RST;
    end else begin
      spd_sw_reg <= spd_sw_next;
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      rdata_reg <= 16'h0000;
    end else begin
      rdata_reg <= rd_next;
    end
  end

  // Receive path: loop transmit data back in place of line data
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      rx_data_reg <= '0;
    end else begin
      rx_data_reg <= rx_sel;
    end
  end

  // Link drops in loopback, port reset, autoneg restart and power down
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      link_reg <= 1'h0;
    end else begin
      link_reg <= link_ok;
    end
  end

  // Speed and role toward the serial interface
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      speed_reg <= `SPC_SPD_RST;
      role_reg  <= 1'h0;
    end else begin
      speed_reg <= spd_live;
      role_reg  <= media_mode_in;
    end
  end

  // Outputs; sequencer levels come straight from the state register
  assign rdata_out         = rdata_reg;
  assign rx_data_out       = rx_data_reg;
  assign port_sm_reset_out = in_prst;
  assign aneg_restart_out  = in_anrs;
  assign aneg_enable_out   = anen_reg;
  assign power_down_out    = powerdown_strap_input_reg;
  assign loopback_out      = loop_reg;
  assign speed_out         = speed_reg;
  assign media_role_out    = role_reg;
  assign link_up_out       = link_reg;

endmodule

`default_nettype wire

//--- tb/spc_ctrl_props.sv
// Port-level assertions for the serial port control bank
`timescale 1ns/1ps
`default_nettype none
`include "spc_defs.svh"
module spc_ctrl_props #(
  parameter int DATA_W   = 8,
  parameter int PRST_CYC = 16,
  parameter int ANRS_CYC = 4
) (
  input wire logic                   ref_clk_in,
  input wire logic                   reset_in,
  input wire logic [`SPC_ADDR_W-1:0] addr_in,
  input wire logic [`SPC_DATA_W-1:0] wdata_in,
  input wire logic                   wr_in,
  input wire logic                   rd_in,
  input wire logic [`SPC_DATA_W-1:0] rdata_out,
  input wire logic                   media_mode_in,
  input wire spc_pkg::spc_speed_t    resolved_speed_in,
  input wire logic [DATA_W-1:0]      tx_data_in,
  input wire logic [DATA_W-1:0]      rx_data_out,
  input wire logic                   port_sm_reset_out,
  input wire logic                   aneg_restart_out,
  input wire logic                   aneg_enable_out,
  input wire logic                   loopback_out
);
  import spc_pkg::*;
  logic [7:0] prst_cnt;
  logic [7:0] anrs_cnt;
  // Accepted control writes; a running port reset blocks them
  wire ctrl_wr = wr_in && addr_in == `SPC_OFF_CTRL && !port_sm_reset_out;
  wire keep_wr = ctrl_wr && !wdata_in[`SPC_B_RESET];
  // High-time counters, cleared as soon as the window drops
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      prst_cnt <= 8'h00;
      anrs_cnt <= 8'h00;
    end else begin
      prst_cnt <= port_sm_reset_out ? prst_cnt + 8'h01 : 8'h00;
      anrs_cnt <= aneg_restart_out ? anrs_cnt + 8'h01 : 8'h00;
    end
  end
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (reset_in);
  a_prst_start: assert property (
    ctrl_wr && wdata_in[`SPC_B_RESET] |=> port_sm_reset_out && !loopback_out)
    else $error("port reset not entered");
  a_prst_len: assert property (
    $fell(port_sm_reset_out) |-> prst_cnt == PRST_CYC)
    else $error("port reset length wrong");
  a_prst_anrs: assert property (
    $fell(port_sm_reset_out) |-> aneg_restart_out)
    else $error("no restart after port reset");
  // Window may be stretched by a new request, so only a floor
  a_anrs_len: assert property (
    $fell(aneg_restart_out) |-> anrs_cnt >= ANRS_CYC)
    else $error("restart window too short");
  a_anen_toggle: assert property (
    keep_wr && wdata_in[`SPC_B_ANEN] != aneg_enable_out
    |=> aneg_restart_out && aneg_enable_out == $past(wdata_in[`SPC_B_ANEN]))
    else $error("enable change without restart");
  a_restart_req: assert property (
    keep_wr && wdata_in[`SPC_B_RESTART] |=> aneg_restart_out)
    else $error("restart request ignored");
  a_loop_data: assert property (
    loopback_out |=> rx_data_out == $past(tx_data_in))
    else $error("loopback data wrong");
  a_speed_track: assert property (
    rd_in && addr_in == `SPC_OFF_CTRL && !media_mode_in
    |=> {rdata_out[`SPC_B_SPD_MSB], rdata_out[`SPC_B_SPD_LSB]} == $past(resolved_speed_in))
    else $error("speed does not track");
endmodule
bind spc_ctrl spc_ctrl_props #(.DATA_W(DATA_W), .PRST_CYC(PRST_CYC), .ANRS_CYC(ANRS_CYC))
  spc_ctrl_props_i (.ref_clk_in, .reset_in, .addr_in, .wdata_in, .wr_in, .rd_in,
  .rdata_out, .media_mode_in, .resolved_speed_in, .tx_data_in, .rx_data_out,
  .port_sm_reset_out, .aneg_restart_out, .aneg_enable_out, .loopback_out);
`default_nettype wire

//--- tb/spc_ctrl_tb_top.sv
// Self-checking bench for the serial port control bank
`timescale 1ns/1ps
`default_nettype none
`include "spc_defs.svh"
module spc_ctrl_tb_top;
  import spc_pkg::*;
  logic        clk = 0, rst = 1, wr = 0, rd = 0, an_s = 0, pd_s = 0, mode = 0, llink = 1;
  logic [4:0]  addr = '0;
  logic [15:0] wd = '0, rdat;
  logic [2:0]  cfg = '0;
  spc_speed_t  rspd = 2'h2, spd;
  logic [7:0]  txd = '0, lrxd = 8'hA5, rxd;
  logic        psm, anr, anen, pdn, lpb, role, lup;
  int          err_count = 0, compares = 0;

  spc_ctrl spc_ctrl_i (.ref_clk_in(clk), .reset_in(rst), .addr_in(addr), .wdata_in(wd),
    .wr_in(wr), .rd_in(rd), .rdata_out(rdat), .autoneg_strap_input_in(an_s),
    .powerdown_strap_input_in(pd_s), .config_strap_in(cfg), .media_mode_in(mode),
    .resolved_speed_in(rspd), .line_link_in(llink), .tx_data_in(txd),
    .line_rx_data_in(lrxd), .rx_data_out(rxd), .port_sm_reset_out(psm),
    .aneg_restart_out(anr), .aneg_enable_out(anen), .power_down_out(pdn),
    .loopback_out(lpb), .speed_out(spd), .media_role_out(role), .link_up_out(lup));

  // 20 MHz clock
  always #25 clk = ~clk;

  task automatic wrap_up();
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(string n, logic [15:0] e, logic [15:0] g);
    compares++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH %s exp %h got %h", n, e, g);
    end
  endtask
  // Just past the edge, so settled outputs are read
  task automatic tick();
    @(posedge clk);
    #1;
  endtask
  // Trailing idle cycle keeps strobes from being set twice in one step
  task automatic wr_reg(logic [4:0] a, logic [15:0] d);
    addr <= a;
    wd <= d;
    wr <= 1'b1;
    tick();
    wr <= 1'b0;
    tick();
  endtask
  task automatic rd_reg(logic [4:0] a, logic [15:0] e, string n);
    addr <= a;
    rd <= 1'b1;
    tick();
    rd <= 1'b0;
    chk(n, e, rdat);
    tick();
    chk({n, " idle"}, 16'h0000, rdat);
  endtask
  task automatic wait_idle();
    for (int i = 0; psm !== 1'b0 || anr !== 1'b0; i++) begin
      if (i == 100) begin
        err_count++;
        $display("MISMATCH idle wait exp 1 got 0");
        wrap_up();
      end
      tick();
    end
  endtask

  task automatic t_straps();
    for (int i = 0; i < 3; i++) begin
      an_s <= (i != 1);
      pd_s <= (i != 2);
      cfg <= (i == 1) ? 3'h4 : 3'h5;
      rst <= 1'b1;
      repeat (8) tick();
      rst <= 1'b0;
      tick();
      chk("anen", 16'(i != 1), 16'(anen));
      chk("powerdown_strap_input", 16'(i == 0), 16'(pdn));
      chk("restart", 16'h1, 16'(anr));
      wait_idle();
      rd_reg(`SPC_OFF_CTRL, {3'h0, 1'(i != 1), 1'(i == 0), 11'h140}, "ctrl");
    end
    rd_reg(5'h1F, 16'h0000, "unmapped");
    $display("test end: straps");
  endtask
  task automatic t_fields();
    wr_reg(`SPC_OFF_CTRL, 16'h1CBF);
    chk("powerdown_strap_input", 16'h1, 16'(pdn));
    rd_reg(`SPC_OFF_CTRL, 16'h1D40, "ctrl rw");
    rspd <= 2'h1;
    rd_reg(`SPC_OFF_CTRL, 16'h3D00, "spd track");
    mode <= 1'b1;
    rspd <= 2'h2;
    wr_reg(`SPC_OFF_CTRL, 16'h3500);
    rd_reg(`SPC_OFF_CTRL, 16'h3500, "spd sw");
    chk("speed", 16'h1, 16'(spd));
    chk("role", 16'h1, 16'(role));
    rd_reg(`SPC_OFF_STAT, 16'h0009, "status");
    mode <= 1'b0;
    tick();
    $display("test end: fields");
  endtask
  task automatic t_loop();
    wr_reg(`SPC_OFF_CTRL, 16'h5500);
    txd <= 8'h3C;
    tick();
    tick();
    chk("rx loop", 16'h3C, 16'(rxd));
    chk("link", 16'h0, 16'(lup));
    rd_reg(`SPC_OFF_STAT, 16'h0000, "status");
    wr_reg(`SPC_OFF_CTRL, 16'h1500);
    tick();
    chk("rx line", 16'hA5, 16'(rxd));
    chk("link", 16'h1, 16'(lup));
    $display("test end: loop");
  endtask
  task automatic t_aneg();
    for (int v = 0; v < 2; v++) begin
      wr_reg(`SPC_OFF_CTRL, {3'h0, 1'(v), 12'h500});
      rd_reg(`SPC_OFF_CTRL, {3'h0, 1'(v), 12'h740}, "toggle");
      chk("link", 16'h0, 16'(lup));
      wait_idle();
    end
    wr_reg(`SPC_OFF_CTRL, 16'h1700);
    chk("restart", 16'h1, 16'(anr));
    wait_idle();
    rd_reg(`SPC_OFF_CTRL, 16'h1540, "self clear");
    $display("test end: aneg");
  endtask
  task automatic t_prst();
    wr_reg(`SPC_OFF_CTRL, 16'h5500);
    wr_reg(`SPC_OFF_CTRL, 16'h8000);
    chk("psm", 16'h1, 16'(psm));
    chk("loop", 16'h0, 16'(lpb));
    rd_reg(`SPC_OFF_CTRL, 16'h9540, "busy");
    wr_reg(`SPC_OFF_CTRL, 16'h0000);
    wait_idle();
    rd_reg(`SPC_OFF_CTRL, 16'h1540, "after");
    $display("test end: port reset");
  endtask

  initial begin
    t_straps();
    t_fields();
    t_loop();
    t_aneg();
    t_prst();
    wrap_up();
  end
endmodule
`default_nettype wire
